// File: hdl/eirq_cfg.svh
// offsets, field positions, reset values and timing counts of the irq block
`ifndef EIRQ_CFG_SVH
`define EIRQ_CFG_SVH

`define EIRQ_OFF_STATUS      8'h24
`define EIRQ_OFF_ENABLE      8'h28
`define EIRQ_BIT_DONE        0
`define EIRQ_BIT_ERR         1
`define EIRQ_BIT_PORT        2
`define EIRQ_BIT_ROLL        3
`define EIRQ_BIT_HSE         4
`define EIRQ_BIT_IAA         5
`define EIRQ_NUM_SRC         6
`define EIRQ_ENABLE_RST      6'h00
`define EIRQ_STATUS_RST      6'h00
`define EIRQ_ENABLE_WMASK    32'h0000_003F
`define EIRQ_STATUS_W1C_MASK 6'h1F
`define EIRQ_THRESH_MASK     6'h23
`define EIRQ_FIDX_BIT_1024   13
`define EIRQ_FIDX_BIT_512    12
`define EIRQ_FIDX_BIT_256    11
`define EIRQ_UFRAME_NS       125000
`define EIRQ_CLK_NS          10
`define EIRQ_UFRAME_CYC      (`EIRQ_UFRAME_NS / `EIRQ_CLK_NS)
`define EIRQ_THRESH_UFRAMES  8

`endif

// File: hdl/eirq_pkg.sv
// types shared by the irq status and enable block
package eirq_pkg;

  typedef enum logic [1:0] {
    EIRQ_FLS_1024 = 2'b00,
    EIRQ_FLS_512  = 2'b01,
    EIRQ_FLS_256  = 2'b10,
    EIRQ_FLS_RSVD = 2'b11
  } eirq_fls_t;

  typedef struct packed {
    logic host_error;
    logic port_change;
    logic xfer_error;
    logic xfer_retire_ioc;
    logic short_packet;
    logic async_advance;
  } eirq_evt_t;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [7:0]  addr;
    logic [31:0] wdata;
  } eirq_bus_t;

endpackage : eirq_pkg

// File: hdl/eirq_rollover.sv
// frame list rollover detector: watches the index bit chosen by list size
`timescale 1ns/1ps
`include "eirq_cfg.svh"
module eirq_rollover
#(
  parameter int IDX_W = 14
)
(
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire logic [IDX_W-1:0]  frame_index,
  input  eirq_pkg::eirq_fls_t    frame_list_size,
  output logic                   rollover
);

  if (IDX_W <= `EIRQ_FIDX_BIT_1024)
  begin : g_bad_width
    $error("eirq_rollover: frame index too narrow");
  end

  typedef struct packed {
    logic [2:0] prev;
    logic       roll;
  } eirq_roll_st_t;

  eirq_roll_st_t st_q;
  eirq_roll_st_t st_d;
  logic [2:0]    taps;

  // taps hold the index bits of the 1024, 512 and 256 entry lists
  function automatic logic pick
  (
    input logic [2:0]          b,
    input eirq_pkg::eirq_fls_t s
  );
    case (s)
      eirq_pkg::EIRQ_FLS_512: pick = b[1];
      eirq_pkg::EIRQ_FLS_256: pick = b[0];
      default:                pick = b[2];
    endcase
  endfunction : pick

  always_comb
  begin
    taps      = {frame_index[`EIRQ_FIDX_BIT_1024],
                 frame_index[`EIRQ_FIDX_BIT_512],
                 frame_index[`EIRQ_FIDX_BIT_256]};
    st_d.prev = taps;
    // same bit old and new, so a list size change is not taken as a wrap
    st_d.roll = pick(taps, frame_list_size)
              ^ pick(st_q.prev, frame_list_size); // [RULE3] [RULE4]
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      st_q <= '0;
    else
      st_q <= st_d;
  end

  assign rollover = st_q.roll;

endmodule : eirq_rollover

// File: hdl/eirq_top.sv
// irq status flags, enable register and threshold-timed host interrupt
// Notes on behaviour
// [RULE1] host bus parity, master or target abort sets system error flag
// [RULE2] system error clears run_stop so no more descriptors execute
// [RULE3] frame index wrap to zero sets rollover flag
// [RULE4] wrap point follows list size: bit 13 for 1024, bit 12 for 512
// [RULE5] owned port change or resume after J-K sets port change flag
// [RULE6] on D3-to-D0, port change flag loads OR of port change bits
// [RULE7] transaction error such as counter underflow sets error flag
// [RULE8] error on descriptor with completion irq sets both flags
// [RULE9] retiring descriptor with completion irq sets done flag
// [RULE10] short packet also sets done flag
// [RULE11] interrupt only while flag active and its enable set
// [RULE12] flags set and readable even with enables clear
// [RULE13] async advance, error and done irqs wait for the threshold
// [RULE14] system error, rollover and port change irqs are immediate
// [RULE15] software clears flag to acknowledge; request then stops
// [RULE16] software writes reserved enable bits as zero
// [RULE17] writing one clears a flag, zero leaves it
// [RULE18] doorbell then next async advance sets async advance flag
// [RULE19] host irq is OR of qualified enabled pending sources
`timescale 1ns/1ps
`include "eirq_cfg.svh"
module eirq_top
#(
  parameter int IDX_W          = 14,
  parameter int UFRAME_CYC     = `EIRQ_UFRAME_CYC,
  parameter int THRESH_UFRAMES = `EIRQ_THRESH_UFRAMES
)
(
  input  wire logic                 REF_CLK,
  input  wire logic                 NRST,
  input  eirq_pkg::eirq_bus_t       REG_BUS,
  output logic [31:0]               REG_RDATA,
  input  eirq_pkg::eirq_evt_t       EVENTS,
  input  wire logic [IDX_W-1:0]     FRAME_INDEX,
  input  eirq_pkg::eirq_fls_t       FRAME_LIST_SIZE,
  input  wire logic                 DOORBELL_RING,
  input  wire logic                 D3_TO_D0,
  input  wire logic                 PORT_CHANGE_ANY,
  output logic                      RUN_STOP_CLEAR,
  output logic                      HOST_IRQ
);

  // th_cnt is seven bits wide; the check allows at most 64 microframes per threshold
  if (UFRAME_CYC < 1 || THRESH_UFRAMES < 1 || THRESH_UFRAMES > 64)
  begin : g_bad_param
    $error("eirq_top: bad threshold parameters");
  end

  localparam int UF_W = $clog2(UFRAME_CYC + 1);

  typedef struct packed {
    logic [`EIRQ_NUM_SRC-1:0] status;
    logic [`EIRQ_NUM_SRC-1:0] enable;
    logic                     iaa_armed;
    logic [UF_W-1:0]          uf_cnt;
    logic [6:0]               th_cnt;
    logic                     th_tick;
    logic [31:0]              rdata;
    logic                     rs_clear;
    logic                     irq;
  } eirq_st_t;

  eirq_st_t                 st_q;
  eirq_st_t                 st_d;
  logic                     roll_evt;
  logic [`EIRQ_NUM_SRC-1:0] set_vec;
  logic [`EIRQ_NUM_SRC-1:0] clr_vec;
  logic [`EIRQ_NUM_SRC-1:0] pend;
  logic                     wr_stat;
  logic                     wr_en;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction : hit

  eirq_rollover #(
    .IDX_W (IDX_W)
  ) u_roll (
    .clk             (REF_CLK),
    .rst_n           (NRST),
    .frame_index     (FRAME_INDEX),
    .frame_list_size (FRAME_LIST_SIZE),
    .rollover        (roll_evt)
  );

  always_comb
  begin
    st_d    = st_q;
    wr_stat = REG_BUS.wr && hit(REG_BUS.addr, `EIRQ_OFF_STATUS);
    wr_en   = REG_BUS.wr && hit(REG_BUS.addr, `EIRQ_OFF_ENABLE);

    set_vec = '0;
    set_vec[`EIRQ_BIT_HSE]  = EVENTS.host_error;                 // [RULE1]
    set_vec[`EIRQ_BIT_ROLL] = roll_evt;                          // [RULE3]
    set_vec[`EIRQ_BIT_PORT] = EVENTS.port_change;                // [RULE5]
    set_vec[`EIRQ_BIT_ERR]  = EVENTS.xfer_error;                 // [RULE7]
    // error and completion can share one descriptor: both bits set
    set_vec[`EIRQ_BIT_DONE] = EVENTS.xfer_retire_ioc  // [RULE8] [RULE9]
                            | EVENTS.short_packet;               // [RULE10]
    // advance only counts once the doorbell has been rung
    set_vec[`EIRQ_BIT_IAA]  = st_q.iaa_armed
                            & EVENTS.async_advance;              // [RULE18]

    if (DOORBELL_RING)
      st_d.iaa_armed = 1'b1;
    else if (set_vec[`EIRQ_BIT_IAA])
      st_d.iaa_armed = 1'b0;

    clr_vec = '0;
    if (wr_stat)
      clr_vec = REG_BUS.wdata[`EIRQ_NUM_SRC-1:0];                // [RULE17]

    // set wins over a same-cycle clear so no event is lost
    st_d.status = (st_q.status & ~clr_vec) | set_vec; // [RULE15] [RULE12]
    // power-up restore of the port change flag
    if (D3_TO_D0)
      st_d.status[`EIRQ_BIT_PORT] = PORT_CHANGE_ANY
                                  | set_vec[`EIRQ_BIT_PORT];     // [RULE6]

    if (wr_en)
      st_d.enable = REG_BUS.wdata[`EIRQ_NUM_SRC-1:0];            // [RULE16]

    // threshold timer in microframes; a tick lasts one cycle
    st_d.th_tick = 1'b0;
    if (st_q.uf_cnt == UF_W'(UFRAME_CYC - 1))
    begin
      st_d.uf_cnt = '0;
      if (st_q.th_cnt == 7'(THRESH_UFRAMES - 1))
      begin
        st_d.th_cnt  = '0;
        st_d.th_tick = 1'b1;
      end
      else
        st_d.th_cnt = st_q.th_cnt + 7'd1;
    end
    else
      st_d.uf_cnt = st_q.uf_cnt + UF_W'(1);

    pend = st_q.status & st_q.enable;                            // [RULE11]
    // immediate sources follow pend; threshold ones latch on the tick
    if (|(pend & ~`EIRQ_THRESH_MASK))                            // [RULE14]
      st_d.irq = 1'b1;
    else if (st_q.th_tick && |(pend & `EIRQ_THRESH_MASK))        // [RULE13]
      st_d.irq = 1'b1;
    else if (st_q.irq && |(pend & `EIRQ_THRESH_MASK))
      st_d.irq = 1'b1;
    else
      st_d.irq = 1'b0;                                           // [RULE19]

    st_d.rs_clear = EVENTS.host_error;                           // [RULE2]

    st_d.rdata = '0;
    if (REG_BUS.rd && hit(REG_BUS.addr, `EIRQ_OFF_STATUS))
      st_d.rdata[`EIRQ_NUM_SRC-1:0] = st_q.status;
    else if (REG_BUS.rd && hit(REG_BUS.addr, `EIRQ_OFF_ENABLE))
      st_d.rdata[`EIRQ_NUM_SRC-1:0] = st_q.enable;
  end

  always_ff @(posedge REF_CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      st_q        <= '0;
      st_q.status <= `EIRQ_STATUS_RST;
      st_q.enable <= `EIRQ_ENABLE_RST;
    end
    else
      st_q <= st_d;
  end

  assign REG_RDATA      = st_q.rdata;
  assign RUN_STOP_CLEAR = st_q.rs_clear;
  assign HOST_IRQ       = st_q.irq;

endmodule : eirq_top

// File: test/eirq_host.sv
// host software model: register writes and reads
`timescale 1ns/1ps
module eirq_host
(
  input  wire logic          clk,
  input  wire logic [31:0]   rdata,
  output eirq_pkg::eirq_bus_t bus
);
  initial bus = '0;
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    // reserved enable bits go out as zero; ones clear status flags
    bus <= '{1'b1, 1'b0, a,
             a == 8'h28 ? v & 32'h0000_003F : v};
    @(posedge clk);
    bus <= '0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk);
    bus <= '{1'b0, 1'b1, a, 32'h0000_0000};
    @(posedge clk);
    bus <= '0;
    #1;
    v = rdata;
  endtask : rd
endmodule : eirq_host

// File: test/eirq_properties.sv
// checker: irq block outputs against its bus and event inputs
`timescale 1ns/1ps
module eirq_properties
#(
  parameter int IDX_W = 14
)
(
  input wire logic             REF_CLK,
  input wire logic             NRST,
  input eirq_pkg::eirq_bus_t   REG_BUS,
  input wire logic [31:0]      REG_RDATA,
  input eirq_pkg::eirq_evt_t   EVENTS,
  input wire logic [IDX_W-1:0] FRAME_INDEX,
  input eirq_pkg::eirq_fls_t   FRAME_LIST_SIZE,
  input wire logic             DOORBELL_RING,
  input wire logic             D3_TO_D0,
  input wire logic             PORT_CHANGE_ANY,
  input wire logic             RUN_STOP_CLEAR,
  input wire logic             HOST_IRQ
);
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (!NRST);
  sequence en_s(v);
    REG_BUS.wr && REG_BUS.addr == 8'h28 && REG_BUS.wdata == v;
  endsequence
  // no source may set a flag around the clear, else set wins
  sequence quiet_s;
    EVENTS == '0 && !D3_TO_D0 && $stable(FRAME_INDEX);
  endsequence
  sequence clr_s;
    quiet_s ##0 (REG_BUS.wr && REG_BUS.addr == 8'h24
      && REG_BUS.wdata[5:0] == 6'h3F);
  endsequence
  rsc_pulse_a:
    assert property (EVENTS.host_error |=> RUN_STOP_CLEAR)
    else $error("run stop clear missing");
  rsc_cause_a:
    assert property (RUN_STOP_CLEAR |-> $past(EVENTS.host_error))
    else $error("run stop clear without error");
  rdata_idle_a:
    assert property (!$past(REG_BUS.rd) || !($past(REG_BUS.addr) inside
      {8'h24, 8'h28}) |-> REG_RDATA == '0)
    else $error("read data not zero");
  en_readback_a:
    assert property ($past(REG_BUS.wr, 2) && $past(REG_BUS.addr, 2) == 8'h28
      && !$past(REG_BUS.wr) && REG_BUS.rd && REG_BUS.addr == 8'h28
      |=> REG_RDATA == (32'h0000_003F & $past(REG_BUS.wdata, 3)))
    else $error("enable readback wrong");
  irq_disable_a:
    assert property (en_s(32'h0000_0000) |=> ##1 !HOST_IRQ)
    else $error("irq with all enables clear");
  irq_clear_a:
    assert property (quiet_s ##1 quiet_s ##1 clr_s ##1 quiet_s |=> !HOST_IRQ)
    else $error("irq after flags cleared");
  syserr_direct_a:
    assert property (en_s(32'h0000_0010) ##[1:2]
      (EVENTS.host_error && !REG_BUS.wr) |-> ##2 HOST_IRQ)
    else $error("system error irq late");
  roll_direct_a:
    assert property (en_s(32'h0000_0008) ##[1:2] ($changed(FRAME_INDEX[13])
      && FRAME_LIST_SIZE == eirq_pkg::EIRQ_FLS_1024 && !REG_BUS.wr)
      |-> ##3 HOST_IRQ)
    else $error("rollover irq late");
endmodule : eirq_properties
bind eirq_top eirq_properties #(.IDX_W(IDX_W)) u_props (
  .REF_CLK(REF_CLK), .NRST(NRST), .REG_BUS(REG_BUS),
  .REG_RDATA(REG_RDATA), .EVENTS(EVENTS), .FRAME_INDEX(FRAME_INDEX),
  .FRAME_LIST_SIZE(FRAME_LIST_SIZE), .DOORBELL_RING(DOORBELL_RING),
  .D3_TO_D0(D3_TO_D0), .PORT_CHANGE_ANY(PORT_CHANGE_ANY),
  .RUN_STOP_CLEAR(RUN_STOP_CLEAR), .HOST_IRQ(HOST_IRQ));

// File: test/eirq_top_bench.sv
// self-checking bench of the irq block through its register bus
`timescale 1ns/1ps
module eirq_top_bench;
  logic                clk, nrst, bell, d3, pc_any, run_clr, irq;
  eirq_pkg::eirq_bus_t bus;
  eirq_pkg::eirq_evt_t ev;
  eirq_pkg::eirq_fls_t lsize;
  logic [31:0]         rdata, d;
  logic [13:0]         fi;
  int                  error_cnt, n_tests, cyc, t1;
  // event pulses and the status bits they must set
  logic [5:0] evt [7] = '{6'h01, 6'h02, 6'h04, 6'h08, 6'h10, 6'h20, 6'h0C};
  logic [5:0] sts [7] = '{6'h20, 6'h01, 6'h01, 6'h02,
                          6'h04, 6'h10, 6'h03};
  eirq_top #(.UFRAME_CYC(10), .THRESH_UFRAMES(2)) dut (
    .REF_CLK(clk), .NRST(nrst), .REG_BUS(bus), .REG_RDATA(rdata),
    .EVENTS(ev), .FRAME_INDEX(fi), .FRAME_LIST_SIZE(lsize),
    .DOORBELL_RING(bell), .D3_TO_D0(d3), .PORT_CHANGE_ANY(pc_any),
    .RUN_STOP_CLEAR(run_clr), .HOST_IRQ(irq));
  eirq_host host (.clk(clk), .rdata(rdata), .bus(bus));
  initial
  begin
    clk = 0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) cyc <= cyc + 1;
  task automatic conclude();
    $display("checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : conclude
  task automatic chk(input string n, input logic [31:0] e, g);
    n_tests++;
    if (g !== e)
    begin
      error_cnt++;
      $display("unexpected %s: expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic rchk(input string n, input logic [7:0] a,
                      input logic [31:0] e);
    host.rd(a, d);
    chk(n, e, d);
  endtask : rchk
  task automatic pulse(input logic [5:0] e);
    @(posedge clk);
    ev <= e;
    @(posedge clk);
    ev <= '0;
  endtask : pulse
  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : settle
  task automatic wait_irq();
    for (int i = 0; i < 60 && irq !== 1'b1; i++) @(negedge clk);
    if (irq !== 1'b1)
    begin
      error_cnt++;
      $display("unexpected irq: expected 1 seen %b", irq);
      conclude();
    end
  endtask : wait_irq
  initial
  begin
    nrst = 0;
    ev = '0;
    fi = '0;
    lsize = eirq_pkg::EIRQ_FLS_1024;
    {bell, d3, pc_any} = '0;
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    rchk("status", 8'h24, 32'h0000_0000);
    rchk("enable", 8'h28, 32'h0000_0000);
    host.wr(8'h28, 32'hFFFF_FFFF);
    rchk("enable", 8'h28, 32'h0000_003F);
    rchk("unmapped", 8'h30, 32'h0000_0000);
    host.wr(8'h28, 32'h0000_0000);
    @(posedge clk);
    bell <= 1'b1;
    @(posedge clk);
    bell <= 1'b0;
    for (int k = 0; k < 7; k++)
    begin
      pulse(evt[k]);
      #1;
      chk("run stop clear", {31'h0, evt[k][5]}, run_clr);
      rchk("status", 8'h24, {26'h0, sts[k]});
      chk("irq", 1'b0, irq);
      host.wr(8'h24, 32'h0000_003F);
    end
    // the doorbell was used up by the first advance, so this one is ignored
    pulse(6'h01);
    rchk("cleared", 8'h24, 32'h0000_0000);
    @(posedge clk);
    pc_any <= 1'b1;
    d3 <= 1'b1;
    @(posedge clk);
    d3 <= 1'b0;
    rchk("port load", 8'h24, 32'h0000_0004);
    for (int k = 0; k < 3; k++)
    begin
      host.wr(8'h24, 32'h0000_003F);
      lsize <= k == 1 ? eirq_pkg::EIRQ_FLS_512 : eirq_pkg::EIRQ_FLS_1024;
      @(posedge clk);
      fi <= fi ^ (k == 0 ? 14'h2000 : 14'h1000);
      // the flag lands two edges after the index moves
      @(posedge clk);
      rchk("rollover", 8'h24, k == 2 ? 32'h0 : 32'h8);
    end
    host.wr(8'h28, 32'h0000_0010);
    pulse(6'h20);
    wait_irq();
    chk("irq", 1'b1, irq);
    host.wr(8'h24, 32'h0000_003F);
    settle(2);
    chk("irq", 1'b0, irq);
    host.wr(8'h28, 32'h0000_0008);
    @(posedge clk);
    fi <= fi ^ 14'h2000;
    wait_irq();
    host.wr(8'h28, 32'h0000_0000);
    settle(2);
    chk("irq", 1'b0, irq);
    host.wr(8'h24, 32'h0000_003F);
    // thresholds are ten-cycle microframes times two here
    host.wr(8'h28, 32'h0000_0001);
    pulse(6'h04);
    wait_irq();
    t1 = cyc;
    host.wr(8'h24, 32'h0000_003F);
    repeat (7) @(posedge clk);
    pulse(6'h04);
    wait_irq();
    chk("irq period", 32'h0, 32'((cyc - t1) % 20));
    conclude();
  end
endmodule : eirq_top_bench
